/* logic/trz_fifo.sv */
/*
  Small synchronous FIFO, flip-flop storage, valid/ready on both sides.
  Assumes one clock and an asynchronous active-high reset in that
  clock's domain.
*/
`timescale 1ns/1ps
module trz_fifo
  import trz_pkg::*;
#(
  parameter int unsigned WIDTH = TRZ_RAIL_W,
  parameter int unsigned DEPTH = TRZ_FIFO_DEP
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CNT_W = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0]            wr_ptr;
    logic [PTR_W-1:0]            rd_ptr;
    logic [CNT_W-1:0]            count;
  } trz_fifo_st_t;

  trz_fifo_st_t st_ff;
  trz_fifo_st_t nxt_st;
  logic         push;
  logic         pop;

  assign in_ready  = (st_ff.count != CNT_W'(DEPTH));
  assign out_valid = (st_ff.count != '0);
  assign out_data  = st_ff.mem[st_ff.rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.mem[st_ff.wr_ptr] = in_data;
      nxt_st.wr_ptr = (st_ff.wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : st_ff.wr_ptr + 1'b1;
    end
    if (pop) begin
      nxt_st.rd_ptr = (st_ff.rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : st_ff.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      nxt_st.count = st_ff.count + 1'b1;
    end else if (pop && !push) begin
      nxt_st.count = st_ff.count - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule

/* logic/trz_pkg.sv */
/*
  Shared constants and types for the transmit rail input and zero
  substitution encoder: register map, field positions, pin bundle
  layout, run lengths and substitution tags.
  Assumes a SystemVerilog-2012 tool; imported whole by each module except trz_framer_model.
*/
package trz_pkg;

  localparam int unsigned TRZ_ADDR_W          = 3;
  localparam int unsigned TRZ_REG_W           = 5;
  localparam logic [2:0]  TRZ_ADDR_TX_CTRL    = 3'h1;
  localparam logic [2:0]  TRZ_ADDR_CODEC_CTRL = 3'h2;
  localparam logic [2:0]  TRZ_ADDR_RATE_CTRL  = 3'h4;
  localparam logic [4:0]  TRZ_REG_RST         = 5'h00;
  localparam logic [4:0]  TRZ_CODEC_MASK      = 5'h0f;

  // transmit_control fields
  localparam int unsigned TRZ_TXC_BIN     = 0;
  localparam int unsigned TRZ_TXC_BLD_DIS = 1;
  localparam int unsigned TRZ_TXC_AOS     = 3;
  localparam int unsigned TRZ_TXC_OFF     = 4;
  // receive_and_codec_control / rate_and_loopback_control fields
  localparam int unsigned TRZ_CDC_BYPASS  = 3;
  localparam int unsigned TRZ_RATE_E3     = 2;

  // Hardware pin bundle layout
  localparam int unsigned TRZ_PIN_HOST = 0;
  localparam int unsigned TRZ_PIN_BLD  = 1;
  localparam int unsigned TRZ_PIN_BYP  = 2;
  localparam int unsigned TRZ_PIN_E3   = 3;
  localparam int unsigned TRZ_PIN_OFF  = 4;
  localparam int unsigned TRZ_PIN_AOS  = 5;
  localparam int unsigned TRZ_PIN_W    = 6;

  localparam int unsigned TRZ_RAIL_W   = 2;
  localparam int unsigned TRZ_RAIL_POS = 0;
  localparam int unsigned TRZ_RAIL_NEG = 1;
  localparam int unsigned TRZ_B3ZS_RUN = 3;
  localparam int unsigned TRZ_HDB3_RUN = 4;
  localparam int unsigned TRZ_WIN      = 4;
  localparam int unsigned TRZ_FIFO_DEP = 4;

  typedef enum logic [1:0] {TRZ_TAG_NONE, TRZ_TAG_B, TRZ_TAG_V, TRZ_TAG_Z} trz_tag_t;

  typedef struct packed {
    logic shutdown;
    logic all_ones;
    logic bin_sel;
    logic bypass;
    logic hdb3;
  } trz_cfg_t;

endpackage

/* logic/trz_tx_encoder.sv */
/*
  Transmit front end: rail input capture on the falling transmit clock
  edge, a four-word FIFO, B3ZS/HDB3 zero substitution with bypass,
  and the build-out enable decision. Configuration registers live in
  the clk domain; the rail path runs on tx_clock_in.
  Assumes the framer owns tx_clock_in and that configuration is
  quasi-static while data flows.
*/
// Overview of operation
// - Dual-rail: both rail inputs are sampled on each falling transmit clock edge.
// - A one on the positive rail gives a positive mark for that bit; the code does so only in bypass, else the encoder picks the polarity.
// - A one on the negative rail gives a negative mark for that bit; the code does so only in bypass, else the encoder picks the polarity.
// - Binary select set: positive rail only, sampled on falling edge, encoded bipolar.
// - In single-rail mode the negative rail input is ignored.
// - DS3 or STS-1: every three-zero run becomes 00V or B0V.
// - Pattern choice keeps an odd pulse count between successive violations.
// - E3: every four-zero run becomes 000V or B00V, same parity choice.
// - Hardware mode: codec bypass pin low enables encoder, high disables it.
// - Host mode: codec bypass bit D3 at 0x02 enables at zero.
// - Encoder disabled: rails go to the line exactly as received.
// - Build-out control low or cleared enables shaped pulse build-out.
// - Build-out control high or set disables build-out, partial shaping.
// - E3 rate always forces build-out off.
// - Host mode: 0x04 E3 bit selects E3, else STS-1 bit picks STS-1/DS3; the code reads only the E3 bit D2.
`timescale 1ns/1ps
module trz_tx_encoder
  import trz_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  reg_wr_en,
  input  wire logic                  reg_rd_en,
  input  wire logic [TRZ_ADDR_W-1:0] reg_addr,
  input  wire logic [TRZ_REG_W-1:0]  reg_wdata,
  output logic      [TRZ_REG_W-1:0]  reg_rdata,
  input  wire logic                  config_mode_select,
  input  wire logic                  hw_build_out_disable,
  input  wire logic                  hw_codec_bypass,
  input  wire logic                  hw_e3_select,
  input  wire logic                  hw_transmitter_shutdown,
  input  wire logic                  hw_send_all_ones,
  output logic                       build_out_enable,
  input  wire logic                  tx_clock_in,
  input  wire logic                  tx_positive_rail_in,
  input  wire logic                  tx_negative_rail_in,
  output logic                       rail_ready,
  output logic                       line_out_tip,
  output logic                       line_out_ring
);

  // clk domain state
  typedef struct packed {
    logic [TRZ_REG_W-1:0] tx_ctrl;
    logic [TRZ_REG_W-1:0] codec_ctrl;
    logic [TRZ_REG_W-1:0] rate_ctrl;
    logic [TRZ_PIN_W-1:0] pin_meta;
    logic [TRZ_PIN_W-1:0] pin_sync;
    trz_cfg_t             cfg;
    logic                 bld_en;
    logic [TRZ_REG_W-1:0] rdata;
  } trz_sys_t;

  // Link domain state, clocked on the falling transmit clock edge
  typedef struct packed {
    trz_cfg_t                            cfg_meta;
    trz_cfg_t                            cfg_sync;
    logic [TRZ_RAIL_W-1:0]               samp;
    logic                                samp_v;
    logic [TRZ_WIN-1:0][TRZ_RAIL_W-1:0]  win_r;
    trz_tag_t [TRZ_WIN-1:0]              win_t;
    logic                                last_pos;
    logic                                odd;
    logic                                tip;
    logic                                ring;
    logic                                ready;
  } trz_link_t;

  trz_sys_t              sys_ff;
  trz_sys_t              nxt_sys;
  trz_link_t             lk_ff;
  trz_link_t             nxt_lk;

  logic                  tx_clk_fall;
  logic                  lrst_meta_ff;
  logic                  lrst_ff;

  logic                  fifo_in_ready;
  logic                  fifo_out_valid;
  logic [TRZ_RAIL_W-1:0] fifo_out_data;
  logic                  pop;

  logic                  host;
  logic                  bld_dis;
  logic                  e3;

  trz_tag_t [TRZ_WIN-1:0] tags;
  logic [TRZ_WIN-1:0]    mark;
  logic                  zeros;
  logic                  pulse;
  logic                  pol;
  int unsigned           run;

  // Falling edge of the framer clock is the sampling edge
  assign tx_clk_fall = ~tx_clock_in;

  // Register file and configuration selection, clk domain

  always_comb begin
    nxt_sys  = sys_ff;
    host     = sys_ff.pin_sync[TRZ_PIN_HOST];
    bld_dis  = 1'b0;
    e3       = 1'b0;

    nxt_sys.pin_meta = {hw_send_all_ones, hw_transmitter_shutdown, hw_e3_select,
                        hw_codec_bypass, hw_build_out_disable, config_mode_select};
    nxt_sys.pin_sync = sys_ff.pin_meta;

    if (reg_wr_en) begin
      unique case (reg_addr)
        TRZ_ADDR_TX_CTRL: begin
          nxt_sys.tx_ctrl = reg_wdata;
        end
        TRZ_ADDR_CODEC_CTRL: begin
          // Top bit is reserved and always reads zero
          nxt_sys.codec_ctrl = reg_wdata & TRZ_CODEC_MASK;
        end
        TRZ_ADDR_RATE_CTRL: begin
          nxt_sys.rate_ctrl = reg_wdata;
        end
        default: begin
        end
      endcase
    end

    nxt_sys.rdata = TRZ_REG_RST;
    if (reg_rd_en) begin
      unique case (reg_addr)
        TRZ_ADDR_TX_CTRL: begin
          nxt_sys.rdata = sys_ff.tx_ctrl;
        end
        TRZ_ADDR_CODEC_CTRL: begin
          nxt_sys.rdata = sys_ff.codec_ctrl;
        end
        TRZ_ADDR_RATE_CTRL: begin
          nxt_sys.rdata = sys_ff.rate_ctrl;
        end
        default: begin
          nxt_sys.rdata = TRZ_REG_RST;
        end
      endcase
    end

    if (host) begin
      // Binary input is a host-only option
      nxt_sys.cfg.bin_sel  = sys_ff.tx_ctrl[TRZ_TXC_BIN];
      bld_dis              = sys_ff.tx_ctrl[TRZ_TXC_BLD_DIS];
      nxt_sys.cfg.all_ones = sys_ff.tx_ctrl[TRZ_TXC_AOS];
      nxt_sys.cfg.shutdown = sys_ff.tx_ctrl[TRZ_TXC_OFF];
      nxt_sys.cfg.bypass   = sys_ff.codec_ctrl[TRZ_CDC_BYPASS];
      // STS-1 and DS3 share B3ZS, so only the E3 bit matters here
      e3                   = sys_ff.rate_ctrl[TRZ_RATE_E3];
    end else begin
      nxt_sys.cfg.bin_sel  = 1'b0;
      bld_dis              = sys_ff.pin_sync[TRZ_PIN_BLD];
      nxt_sys.cfg.all_ones = sys_ff.pin_sync[TRZ_PIN_AOS];
      nxt_sys.cfg.shutdown = sys_ff.pin_sync[TRZ_PIN_OFF];
      nxt_sys.cfg.bypass   = sys_ff.pin_sync[TRZ_PIN_BYP];
      e3                   = sys_ff.pin_sync[TRZ_PIN_E3];
    end
    nxt_sys.cfg.hdb3 = e3;

    nxt_sys.bld_en = ~bld_dis & ~e3;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sys_ff <= '0;
    end else begin
      sys_ff <= nxt_sys;
    end
  end

  assign reg_rdata        = sys_ff.rdata;
  assign build_out_enable = sys_ff.bld_en;

  // Link reset: asserts at once, releases on the link clock
  always_ff @(posedge tx_clk_fall or posedge rst) begin
    if (rst) begin
      lrst_meta_ff <= 1'b1;
      lrst_ff      <= 1'b1;
    end else begin
      lrst_meta_ff <= 1'b0;
      lrst_ff      <= lrst_meta_ff;
    end
  end

  // Shutdown stalls the drain, so back-pressure reaches the framer
  assign pop = fifo_out_valid & ~lk_ff.cfg_sync.shutdown;

  trz_fifo #(
    .WIDTH (TRZ_RAIL_W),
    .DEPTH (TRZ_FIFO_DEP)
  ) u_fifo (
    .clk       (tx_clk_fall),
    .rst       (lrst_ff),
    .in_valid  (lk_ff.samp_v),
    .in_ready  (fifo_in_ready),
    .in_data   (lk_ff.samp),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out_data)
  );

  // Encoder, link domain

  always_comb begin
    nxt_lk = lk_ff;
    tags   = lk_ff.win_t;
    mark   = '0;
    zeros  = 1'b1;
    pulse  = 1'b0;
    pol    = 1'b0;
    run    = lk_ff.cfg_sync.hdb3 ? TRZ_HDB3_RUN : TRZ_B3ZS_RUN;

    // Config is quasi-static; bits may land a cycle apart
    nxt_lk.cfg_meta = sys_ff.cfg;
    nxt_lk.cfg_sync = lk_ff.cfg_meta;

    nxt_lk.samp[TRZ_RAIL_POS] = tx_positive_rail_in | lk_ff.cfg_sync.all_ones;
    nxt_lk.samp[TRZ_RAIL_NEG] = tx_negative_rail_in & ~lk_ff.cfg_sync.bin_sel
                                & ~lk_ff.cfg_sync.all_ones;
    nxt_lk.samp_v = 1'b1;
    nxt_lk.ready  = fifo_in_ready;
    nxt_lk.tip    = 1'b0;
    nxt_lk.ring   = 1'b0;

    // Either rail marks a one (positive rail only when binary select is set); the encoder chooses polarity itself
    for (int i = 0; i < TRZ_WIN; i++) begin
      mark[i] = lk_ff.cfg_sync.bin_sel ? lk_ff.win_r[i][TRZ_RAIL_POS]
                                       : |lk_ff.win_r[i];
      if ((i < run) && mark[i]) begin
        zeros = 1'b0;
      end
    end

    if (pop) begin
      // Untagged head with a full zero run ahead starts a substitution
      if (!lk_ff.cfg_sync.bypass && tags[0] == TRZ_TAG_NONE && zeros) begin
        tags[0] = lk_ff.odd ? TRZ_TAG_Z : TRZ_TAG_B;
        for (int i = 1; i < TRZ_WIN; i++) begin
          if (i + 1 < run) begin
            tags[i] = TRZ_TAG_Z;
          end else if (i + 1 == run) begin
            tags[i] = TRZ_TAG_V;
          end
        end
      end

      if (lk_ff.cfg_sync.bypass) begin
        nxt_lk.tip  = lk_ff.win_r[0][TRZ_RAIL_POS];
        nxt_lk.ring = lk_ff.win_r[0][TRZ_RAIL_NEG];
      end else begin
        unique case (tags[0])
          TRZ_TAG_NONE: begin
            pulse = mark[0];
            pol   = ~lk_ff.last_pos;
          end
          TRZ_TAG_B: begin
            pulse = 1'b1;
            pol   = ~lk_ff.last_pos;
          end
          TRZ_TAG_V: begin
            pulse = 1'b1;
            pol   = lk_ff.last_pos;
          end
          TRZ_TAG_Z: begin
            pulse = 1'b0;
          end
        endcase
        if (pulse) begin
          nxt_lk.tip      = pol;
          nxt_lk.ring     = ~pol;
          nxt_lk.last_pos = pol;
          nxt_lk.odd      = (tags[0] == TRZ_TAG_V) ? 1'b0 : ~lk_ff.odd;
        end
      end

      for (int i = 0; i < TRZ_WIN - 1; i++) begin
        nxt_lk.win_r[i] = lk_ff.win_r[i + 1];
        nxt_lk.win_t[i] = tags[i + 1];
      end
      nxt_lk.win_r[TRZ_WIN - 1] = fifo_out_data;
      nxt_lk.win_t[TRZ_WIN - 1] = TRZ_TAG_NONE;
    end
  end

  always_ff @(posedge tx_clk_fall or posedge lrst_ff) begin
    if (lrst_ff) begin
      lk_ff <= '0;
    end else begin
      lk_ff <= nxt_lk;
    end
  end

  assign rail_ready    = lk_ff.ready;
  assign line_out_tip  = lk_ff.tip;
  assign line_out_ring = lk_ff.ring;

endmodule

/* sim/tb.sv */
/*
  Bench for the transmit encoder: registers, pins and line traffic.
  Assumes the framer model owns the link clock and the rails.
*/
`timescale 1ns/1ps
module tb
  import trz_pkg::*;
;
  localparam logic [2:0] A_TX = TRZ_ADDR_TX_CTRL;
  localparam logic [2:0] A_CD = TRZ_ADDR_CODEC_CTRL;
  localparam logic [2:0] A_RT = TRZ_ADDR_RATE_CTRL;
  logic       clk = 1'b0, rst = 1'b1, reg_wr_en = 1'b0, reg_rd_en = 1'b0;
  logic       config_mode_select = 1'b0, hw_build_out_disable = 1'b0;
  logic       hw_codec_bypass = 1'b0, hw_e3_select = 1'b0, dual = 1'b0, neg_noise = 1'b0;
  logic       mon = 1'b0, exact = 1'b0, lp = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [4:0] reg_wdata = 5'h00;
  logic [4:0] reg_rdata;
  logic       build_out_enable, rail_ready, tx_clock_in, tx_positive_rail_in;
  logic       tx_negative_rail_in, line_out_tip, line_out_ring;
  logic [1:0] hist [0:7];
  int         mismatches, total_checks, cycles, zr, maxz, np, nv, bad;

  trz_tx_encoder i_trz_tx_encoder (
    .clk, .rst, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata,
    .config_mode_select, .hw_build_out_disable, .hw_codec_bypass, .hw_e3_select,
    .hw_transmitter_shutdown(1'b0), .hw_send_all_ones(1'b0), .build_out_enable,
    .tx_clock_in, .tx_positive_rail_in, .tx_negative_rail_in, .rail_ready,
    .line_out_tip, .line_out_ring
  );
  trz_framer_model i_trz_framer_model (
    .tx_clock_in, .tx_positive_rail_in, .tx_negative_rail_in, .dual, .neg_noise
  );

  always #50 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (mismatches == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk_reg(input logic [4:0] got, input logic [4:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: reg %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [4:0] d);
    @(negedge clk);
    reg_wr_en = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr_en = 1'b0;
  endtask
  // Entered at a falling edge, so it can follow a write back to back
  task automatic rd(input logic [2:0] a, input logic [4:0] exp);
    reg_rd_en = 1'b1;
    reg_addr  = a;
    @(negedge clk);
    reg_rd_en = 1'b0;
    chk_reg(reg_rdata, exp);
    @(negedge clk);
  endtask
  task automatic pins(input logic h, input logic b, input logic y, input logic e);
    @(negedge clk);
    config_mode_select   = h;
    hw_build_out_disable = b;
    hw_codec_bypass      = y;
    hw_e3_select         = e;
  endtask
  task automatic boe(input logic exp);
    repeat (6) @(negedge clk);
    chk_val({15'h0000, build_out_enable}, {15'h0000, exp});
  endtask
  // Static line state as {rail_ready, ring, tip}, after the FIFO has flushed
  task automatic line_chk(input logic [2:0] exp);
    repeat (24) @(negedge tx_clock_in);
    @(posedge tx_clock_in);
    chk_val({13'h0000, rail_ready, line_out_ring, line_out_tip}, {13'h0000, exp});
  endtask
  // Encoded phases judged by longest space run and violation spacing
  task automatic run_phase(input logic d, input logic ex, input int expz);
    dual = d;
    repeat (24) @(negedge tx_clock_in);
    zr    = 0;
    maxz  = 0;
    np    = -1;
    nv    = 0;
    bad   = 0;
    exact = ex;
    mon   = 1'b1;
    repeat (96) @(negedge tx_clock_in);
    mon = 1'b0;
    @(posedge tx_clock_in);
    chk_val({15'h0000, rail_ready}, 16'h0001);
    if (!ex) begin
      chk_val(16'(maxz), 16'(expz));
      chk_val(16'(bad), 16'h0000);
      chk_val({15'h0000, nv > 1}, 16'h0001);
    end
  endtask

  // Line outputs change on the falling edge; look half a bit later
  always @(posedge tx_clock_in) begin
    for (int i = 7; i > 0; i--) begin
      hist[i] = hist[i-1];
    end
    hist[0] = {tx_negative_rail_in, tx_positive_rail_in};
    if (mon && exact) begin
      chk_val({14'h0000, line_out_ring, line_out_tip}, {14'h0000, hist[6]});
    end else if (mon && !line_out_tip && !line_out_ring) begin
      zr++;
      maxz = (zr > maxz) ? zr : maxz;
    end else if (mon) begin
      zr = 0;
      if (np < 0) begin
        np = 0;
      end else if (line_out_tip == lp) begin
        bad = bad + ((nv > 0 && np % 2 == 0) ? 1 : 0);
        nv++;
        np = 0;
      end else begin
        np++;
      end
      lp = line_out_tip;
    end
  end

  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    for (int a = 1; a < 5; a++) begin
      rd(3'(a), 5'h00);
    end
    wr(A_TX, 5'h1f);
    rd(A_TX, 5'h1f);
    wr(A_CD, 5'h1f);
    rd(A_CD, 5'h0f);
    wr(3'h3, 5'h1f);
    rd(3'h3, 5'h00);
    wr(A_TX, 5'h00);
    rd(A_TX, 5'h00);
    wr(A_CD, 5'h00);
    rd(A_CD, 5'h00);
    pins(1'b0, 1'b0, 1'b1, 1'b0);
    run_phase(1'b1, 1'b1, 0);
    pins(1'b0, 1'b0, 1'b0, 1'b0);
    run_phase(1'b0, 1'b0, 2);
    boe(1'b1);
    pins(1'b0, 1'b1, 1'b0, 1'b0);
    boe(1'b0);
    pins(1'b0, 1'b0, 1'b0, 1'b1);
    run_phase(1'b0, 1'b0, 3);
    boe(1'b0);
    pins(1'b1, 1'b0, 1'b0, 1'b0);
    wr(A_TX, 5'h01);
    rd(A_TX, 5'h01);
    neg_noise = 1'b1;
    run_phase(1'b0, 1'b0, 2);
    boe(1'b1);
    wr(A_TX, 5'h03);
    rd(A_TX, 5'h03);
    boe(1'b0);
    wr(A_TX, 5'h01);
    rd(A_TX, 5'h01);
    wr(A_RT, 5'h0c);
    rd(A_RT, 5'h0c);
    run_phase(1'b0, 1'b0, 3);
    boe(1'b0);
    wr(A_RT, 5'h08);
    rd(A_RT, 5'h08);
    run_phase(1'b0, 1'b0, 2);
    boe(1'b1);
    wr(A_TX, 5'h00);
    rd(A_TX, 5'h00);
    wr(A_CD, 5'h08);
    rd(A_CD, 5'h08);
    neg_noise = 1'b0;
    run_phase(1'b1, 1'b1, 0);
    wr(A_TX, 5'h10);
    line_chk(3'h0);
    wr(A_TX, 5'h08);
    line_chk(3'h5);
    end_sim();
  end
endmodule

/* sim/trz_framer_model.sv */
/*
  Framer stand-in: free-running link clock and rail patterns.
  Assumes the bench picks dual-rail traffic and negative-rail noise.
*/
`timescale 1ns/1ps
module trz_framer_model (
  output logic      tx_clock_in,
  output logic      tx_positive_rail_in,
  output logic      tx_negative_rail_in,
  input  wire logic dual,
  input  wire logic neg_noise
);
  // Runs of one to four zeros, so both codes must substitute
  localparam logic [15:0] POS_PAT = 16'h890b;
  localparam logic [15:0] NEG_PAT = 16'h5a3c;
  logic [3:0] idx = 4'h0;
  initial begin
    tx_clock_in         = 1'b0;
    tx_positive_rail_in = 1'b0;
    tx_negative_rail_in = 1'b0;
    #13;
    forever #32 tx_clock_in = ~tx_clock_in;
  end
  // Rails move at the rising edge, half a bit before sampling
  always @(posedge tx_clock_in) begin
    idx                 <= idx + 4'h1;
    tx_positive_rail_in <= POS_PAT[idx];
    tx_negative_rail_in <= dual ? NEG_PAT[idx] : neg_noise;
  end
endmodule

/* sim/trz_tx_encoder_props.sv */
/*
  Checker for the transmit encoder: readback, build-out and line output.
  Assumes it is bound to trz_tx_encoder and sees only its ports.
*/
`timescale 1ns/1ps
module trz_tx_encoder_props
  import trz_pkg::*;
(
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic                  reg_wr_en,
  input wire logic                  reg_rd_en,
  input wire logic [TRZ_ADDR_W-1:0] reg_addr,
  input wire logic [TRZ_REG_W-1:0]  reg_wdata,
  input wire logic [TRZ_REG_W-1:0]  reg_rdata,
  input wire logic                  config_mode_select,
  input wire logic                  hw_build_out_disable,
  input wire logic                  hw_codec_bypass,
  input wire logic                  hw_e3_select,
  input wire logic                  build_out_enable,
  input wire logic                  tx_clock_in,
  input wire logic                  tx_positive_rail_in,
  input wire logic                  tx_negative_rail_in,
  input wire logic                  line_out_tip,
  input wire logic                  line_out_ring
);
  // Pins cross two domains, so wait well past the sync and pipeline
  logic [4:0] settle_ff;
  logic [2:0] pins_ff;
  logic       hw_ok;
  always_ff @(negedge tx_clock_in or posedge rst) begin
    if (rst) begin
      settle_ff <= 5'h00;
      pins_ff   <= 3'h0;
    end else begin
      pins_ff   <= {config_mode_select, hw_codec_bypass, hw_e3_select};
      settle_ff <= (pins_ff != {config_mode_select, hw_codec_bypass, hw_e3_select}) ? 5'h00
                 : settle_ff + {4'h0, settle_ff != 5'h1f};
    end
  end
  // A pin that moved since the last link edge already voids the check
  assign hw_ok = (settle_ff == 5'h1f) && !config_mode_select
               && (pins_ff == {config_mode_select, hw_codec_bypass, hw_e3_select});

  a_codec_readback:
    assert property (@(posedge clk) disable iff (rst)
      (reg_wr_en && reg_addr == TRZ_ADDR_CODEC_CTRL) ##1
      (reg_rd_en && !reg_wr_en && reg_addr == TRZ_ADDR_CODEC_CTRL)
      |=> reg_rdata[TRZ_CDC_BYPASS] == $past(reg_wdata[TRZ_CDC_BYPASS], 2))
      else $error("codec bit readback wrong");
  a_buildout_on:
    assert property (@(posedge clk) disable iff (rst)
      (!config_mode_select && !hw_build_out_disable && !hw_e3_select) [*6]
      |-> build_out_enable) else $error("build-out not on");
  a_buildout_off:
    assert property (@(posedge clk) disable iff (rst)
      (!config_mode_select && hw_build_out_disable) [*6] |-> !build_out_enable)
      else $error("build-out not off");
  a_e3_forces_off:
    assert property (@(posedge clk) disable iff (rst)
      (!config_mode_select && hw_e3_select) [*6] |-> !build_out_enable)
      else $error("build-out on at E3");
  a_tip_follows_pos:
    assert property (@(negedge tx_clock_in) disable iff (rst)
      hw_ok && hw_codec_bypass |-> line_out_tip == $past(tx_positive_rail_in, 7))
      else $error("tip differs from positive rail");
  a_ring_follows_neg:
    assert property (@(negedge tx_clock_in) disable iff (rst)
      hw_ok && hw_codec_bypass |-> line_out_ring == $past(tx_negative_rail_in, 7))
      else $error("ring differs from negative rail");
  a_b3zs_no_gap:
    assert property (@(negedge tx_clock_in) disable iff (rst)
      (hw_ok && !hw_codec_bypass && !hw_e3_select && !line_out_tip && !line_out_ring) [*3]
      |-> 1'b0) else $error("three spaces in B3ZS");
  a_hdb3_no_gap:
    assert property (@(negedge tx_clock_in) disable iff (rst)
      (hw_ok && !hw_codec_bypass && hw_e3_select && !line_out_tip && !line_out_ring) [*4]
      |-> 1'b0) else $error("four spaces in HDB3");
endmodule

bind trz_tx_encoder trz_tx_encoder_props i_trz_tx_encoder_props (
  .clk, .rst, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata,
  .config_mode_select, .hw_build_out_disable, .hw_codec_bypass, .hw_e3_select,
  .build_out_enable, .tx_clock_in, .tx_positive_rail_in, .tx_negative_rail_in,
  .line_out_tip, .line_out_ring
);
